// [acq_decode.sv]
// What this block does
// - card answers sixteen consecutive I/O addresses
// - switch positions 1-5 give A8-A4, ON=0
// - A9 fixed one, A3-A0 base zero
// - factory switch setting decodes base 220h
// - conversion trigger internal or external by jumper
// - internal trigger: software or pacer by mode
// - three separately loadable 16-bit down counters
// - counter 2 clocked from fixed 2MHz
// - counter 1 clocked from counter 2 output
// - counter 0 clock: internal 2MHz or external
// - DMA request/acknowledge on channel 1 or 3
// - interrupt on one selected line, default 15
`timescale 1ns/1ps
`default_nettype none
`include "acq_decode_cfg.svh"

module acq_decode #(
    parameter int OSC_DIV = `OSC_DIV
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [9:0] addr_i,
    input wire logic aen_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic card_select_o,
    input wire logic [4:0] base_select_switch_i,
    input wire logic trigger_source_jumper_i,
    input wire logic clock_source_jumper_i,
    input wire logic dma_channel_jumper_a_i,
    input wire logic dma_channel_jumper_b_i,
    input wire logic [3:0] irq_select_i,
    input wire logic ext_trigger_i,
    input wire logic ext_clock_i,
    input wire logic data_ready_i,
    input wire logic dack1_n_i,
    input wire logic dack3_n_i,
    output logic drq1_o,
    output logic drq3_o,
    output logic dma_ack_o,
    output logic adc_start_o,
    output logic [2:0] counter_out_o,
    output logic [15:0] irq_line_o,
    output logic [15:0] irq_line_oe_o,
    output logic irq_o
);

    localparam int SYNC_W = 17;

    // ============================================================
    // two-flop synchronisers for the switch, jumper, external clock/trigger and dack pin inputs
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    // factory values until the first samples arrive
    localparam logic [SYNC_W-1:0] SYNC_RESET = {`FACTORY_SWITCH, 4'h0,
                                                `FACTORY_IRQ, 2'b00,
                                                2'b11};

    assign pin_raw = {base_select_switch_i, trigger_source_jumper_i,
                      clock_source_jumper_i, dma_channel_jumper_a_i,
                      dma_channel_jumper_b_i, irq_select_i,
                      ext_trigger_i, ext_clock_i, dack1_n_i, dack3_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge core_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_reg[gi] <= SYNC_RESET[gi];
                    sync_reg[gi] <= SYNC_RESET[gi];
                end else begin
                    meta_reg[gi] <= pin_raw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic [4:0] switch_s;
    acq_decode_pkg::board_select_t board_s;
    logic [3:0] irq_sel_s;
    logic ext_trig_s;
    logic ext_clk_s;
    logic dack1_n_s;
    logic dack3_n_s;

    assign switch_s = sync_reg[16:12];
    assign board_s = sync_reg[11:8];
    assign irq_sel_s = sync_reg[7:4];
    assign ext_trig_s = sync_reg[3];
    assign ext_clk_s = sync_reg[2];
    assign dack1_n_s = sync_reg[1];
    assign dack3_n_s = sync_reg[0];

    // ============================================================
    // edge detect on synchronised external pins
    logic ext_trig_d_reg;
    logic ext_clk_d_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_trig_d_reg <= 1'b0;
            ext_clk_d_reg <= 1'b0;
        end else begin
            ext_trig_d_reg <= ext_trig_s;
            ext_clk_d_reg <= ext_clk_s;
        end
    end

    logic ext_trig_rise;
    logic ext_clk_rise;
    assign ext_trig_rise = ext_trig_s & ~ext_trig_d_reg;
    assign ext_clk_rise = ext_clk_s & ~ext_clk_d_reg;

    // ============================================================
    // address decode
    acq_decode_pkg::bus_req_t req;
    logic [5:0] base_hi;
    logic hit;
    logic [3:0] idx;

    assign req = '{addr: addr_i, aen: aen_i, wr: wr_i, rd: rd_i,
                   wdata: wdata_i};
    // switch open reads 1, closed (ON) reads 0
    assign base_hi = {`BASE_A9, switch_s};
    assign hit = (req.addr[9:4] == base_hi) && !req.aen;
    assign idx = req.addr[3:0];

    logic wr_hit;
    logic rd_hit;
    assign wr_hit = hit && req.wr;
    assign rd_hit = hit && req.rd;

    // ============================================================
    // 2MHz pacer time base
    logic [$clog2(OSC_DIV)-1:0] div_reg;
    logic osc_tick_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= '0;
            osc_tick_reg <= 1'b0;
        end else if (div_reg == $bits(div_reg)'(OSC_DIV - 1)) begin
            div_reg <= '0;
            osc_tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            osc_tick_reg <= 1'b0;
        end
    end

    // ============================================================
    // interval timer chain
    logic [2:0] cnt_tick;
    logic [2:0] cnt_load;
    logic [2:0] cnt_out;
    logic [15:0] cnt_val [3];

    assign cnt_tick[2] = osc_tick_reg;
    assign cnt_tick[1] = cnt_out[2];
    assign cnt_tick[0] = board_s.external_clock_select ?
                         ext_clk_rise : osc_tick_reg;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            assign cnt_load[gi] = wr_hit && (idx == 4'(gi));
            down_counter #(
                .WIDTH(16)
            ) u_cnt (
                .core_clk_i(core_clk_i),
                .arst_n_i(arst_n_i),
                .tick_i(cnt_tick[gi]),
                .load_i(cnt_load[gi]),
                .load_val_i(req.wdata),
                .count_o(cnt_val[gi]),
                .out_pulse_o(cnt_out[gi])
            );
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            counter_out_o <= 3'h0;
        end else begin
            counter_out_o <= cnt_out;
        end
    end

    // ============================================================
    // mode register and conversion trigger
    logic mode_pacer_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_pacer_reg <= `RESET_MODE;
        end else if (wr_hit && idx == `REG_MODE) begin
            mode_pacer_reg <= req.wdata[`MODE_PACER_BIT];
        end
    end

    acq_decode_pkg::trig_origin_t trig_origin;

    always_comb begin
        trig_origin = acq_decode_pkg::TRIG_NONE;
        if (board_s.external_trigger_select) begin
            if (ext_trig_rise) begin
                trig_origin = acq_decode_pkg::TRIG_EXTERNAL;
            end
        end else if (mode_pacer_reg) begin
            if (cnt_out[1]) begin
                trig_origin = acq_decode_pkg::TRIG_PACER;
            end
        end else if (wr_hit && idx == `REG_SOFT_TRIG) begin
            trig_origin = acq_decode_pkg::TRIG_SOFTWARE;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            adc_start_o <= 1'b0;
        end else begin
            adc_start_o <= (trig_origin != acq_decode_pkg::TRIG_NONE);
        end
    end

    // ============================================================
    // dma routing
    acq_decode_pkg::dma_route_t dma_route;
    logic dma_req_reg;
    logic dack_sel;

    always_comb begin
        case ({board_s.dma_channel_jumper_a, board_s.dma_channel_jumper_b})
            2'b10: dma_route = acq_decode_pkg::DMA_CH1;
            2'b01: dma_route = acq_decode_pkg::DMA_CH3;
            default: dma_route = acq_decode_pkg::DMA_OFF;
        endcase
    end

    always_comb begin
        case (dma_route)
            acq_decode_pkg::DMA_CH1: dack_sel = !dack1_n_s;
            acq_decode_pkg::DMA_CH3: dack_sel = !dack3_n_s;
            default: dack_sel = 1'b0;
        endcase
    end

    // a new data word wins over an acknowledge in the same cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dma_req_reg <= 1'b0;
        end else if (data_ready_i && dma_route != acq_decode_pkg::DMA_OFF) begin
            dma_req_reg <= 1'b1;
        end else if (dack_sel) begin
            dma_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drq1_o <= 1'b0;
            drq3_o <= 1'b0;
            dma_ack_o <= 1'b0;
        end else begin
            drq1_o <= dma_req_reg && dma_route == acq_decode_pkg::DMA_CH1;
            drq3_o <= dma_req_reg && dma_route == acq_decode_pkg::DMA_CH3;
            dma_ack_o <= dack_sel;
        end
    end

    // ============================================================
    // interrupt status, clear and enable
    logic [`EVT_WIDTH-1:0] int_status_reg;
    logic [`EVT_WIDTH-1:0] int_enable_reg;
    logic [`EVT_WIDTH-1:0] evt;
    logic [`EVT_WIDTH-1:0] clr;

    assign evt[`EVT_CONV_START] = adc_start_o;
    assign evt[`EVT_DATA_READY] = data_ready_i;
    assign evt[`EVT_COUNT0_OUT] = cnt_out[0];
    assign clr = (wr_hit && idx == `REG_INT_CLEAR) ?
                 req.wdata[`EVT_WIDTH-1:0] : '0;

    // set beats clear when both land in one cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_status_reg <= '0;
        end else begin
            int_status_reg <= (int_status_reg & ~clr) | evt;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            int_enable_reg <= `RESET_INT_ENABLE;
        end else if (wr_hit && idx == `REG_INT_ENABLE) begin
            int_enable_reg <= req.wdata[`EVT_WIDTH-1:0];
        end
    end

    logic int_active;
    assign int_active = |(int_status_reg & int_enable_reg);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
            irq_line_o <= 16'h0000;
            irq_line_oe_o <= 16'h0000;
        end else begin
            irq_o <= int_active;
            irq_line_o <= int_active ? (16'h0001 << irq_sel_s) : 16'h0000;
            irq_line_oe_o <= 16'h0001 << irq_sel_s;
        end
    end

    // ============================================================
    // read data, one cycle after the strobe
    logic [15:0] rdata_next;

    always_comb begin
        rdata_next = 16'h0000;
        case (idx)
            `REG_COUNT0: rdata_next = cnt_val[0];
            `REG_COUNT1: rdata_next = cnt_val[1];
            `REG_COUNT2: rdata_next = cnt_val[2];
            `REG_MODE: rdata_next = {15'h0000, mode_pacer_reg};
            `REG_INT_STATUS: rdata_next = {13'h0000, int_status_reg};
            `REG_INT_ENABLE: rdata_next = {13'h0000, int_enable_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 16'h0000;
            card_select_o <= 1'b0;
        end else begin
            rdata_o <= rd_hit ? rdata_next : 16'h0000;
            card_select_o <= hit && (req.wr || req.rd);
        end
    end

endmodule : acq_decode
`default_nettype wire

// [acq_decode_cfg.svh]
`ifndef ACQ_DECODE_CFG_SVH
`define ACQ_DECODE_CFG_SVH

// ============================================================
// register indices inside the 16-location window
`define REG_COUNT0 4'h0
`define REG_COUNT1 4'h1
`define REG_COUNT2 4'h2
`define REG_MODE 4'h4
`define REG_SOFT_TRIG 4'h5
`define REG_INT_STATUS 4'h6
`define REG_INT_CLEAR 4'h7
`define REG_INT_ENABLE 4'h8

// ============================================================
// mode register fields
`define MODE_PACER_BIT 0

// ============================================================
// interrupt event bit positions
`define EVT_CONV_START 0
`define EVT_DATA_READY 1
`define EVT_COUNT0_OUT 2
`define EVT_WIDTH 3

// ============================================================
// address decode
`define ADDR_WIDTH 10
`define BASE_A9 1'b1
`define WINDOW_WORDS 16
// switch positions 1..5 -> A8..A4, factory setting gives base 220h
`define FACTORY_SWITCH 5'h02
`define FACTORY_IRQ 4'hf

// ============================================================
// reset values
`define RESET_MODE 1'b0
`define RESET_INT_ENABLE 3'h0
`define RESET_COUNT 16'h0000

// ============================================================
// timing
`define CORE_CLK_HZ 200000000
`define OSC_HZ 2000000
`define OSC_DIV (`CORE_CLK_HZ / `OSC_HZ)

`endif

// [acq_decode_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// port checker
module acq_decode_chk (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic [9:0] addr_i,
    input wire logic aen_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic card_select_o,
    input wire logic drq1_o,
    input wire logic drq3_o,
    input wire logic adc_start_o,
    input wire logic [2:0] counter_out_o,
    input wire logic [15:0] irq_line_o,
    input wire logic [15:0] irq_line_oe_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sel_aen_a: assert property ($past(aen_i) |-> !card_select_o)
        else $error("select in a dma cycle");
    sel_cause_a: assert property (card_select_o |->
        $past(wr_i || rd_i) && $past(addr_i[9]))
        else $error("select without strobe or A9");
    rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside read answer");
    drq_excl_a: assert property (!(drq1_o && drq3_o))
        else $error("both dma channels requested");
    irq_one_a: assert property ($onehot0(irq_line_oe_o) &&
        (irq_line_o & ~irq_line_oe_o) == 16'h0000)
        else $error("interrupt on unselected line");
    start_pulse_a: assert property (adc_start_o |=> !adc_start_o)
        else $error("start pulse too long");
    c2_rate_a: assert property (counter_out_o[2] |=>
        !counter_out_o[2] [*3])
        else $error("counter 2 faster than its clock");
    c1_cascade_a: assert property (counter_out_o[1] |->
        counter_out_o[2] || $past(counter_out_o[2]) ||
        $past(counter_out_o[2], 2) || $past(counter_out_o[2], 3))
        else $error("counter 1 not driven by counter 2");
endmodule : acq_decode_chk

bind acq_decode acq_decode_chk u_chk (
    .core_clk_i, .arst_n_i, .addr_i, .aen_i, .wr_i, .rd_i, .rdata_o,
    .card_select_o, .drq1_o, .drq3_o, .adc_start_o, .counter_out_o,
    .irq_line_o, .irq_line_oe_o
);
`default_nettype wire

// [acq_decode_pkg.sv]
package acq_decode_pkg;

    // ============================================================
    // board-level selects as seen after synchronisation
    typedef struct packed {
        logic external_trigger_select;
        logic external_clock_select;
        logic dma_channel_jumper_a;
        logic dma_channel_jumper_b;
    } board_select_t;

    // ============================================================
    // conversion trigger origin
    typedef enum logic [1:0] {
        TRIG_NONE,
        TRIG_SOFTWARE,
        TRIG_PACER,
        TRIG_EXTERNAL
    } trig_origin_t;

    // ============================================================
    // dma routing
    typedef enum logic [1:0] {
        DMA_OFF,
        DMA_CH1,
        DMA_CH3
    } dma_route_t;

    // ============================================================
    // register bus access
    typedef struct packed {
        logic [9:0] addr;
        logic aen;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } bus_req_t;

endpackage : acq_decode_pkg

// [down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acq_decode_cfg.svh"

module down_counter #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] load_val_i,
    output logic [WIDTH-1:0] count_o,
    output logic out_pulse_o
);

    logic [WIDTH-1:0] reload_reg;
    logic [WIDTH-1:0] count_reg;
    logic out_reg;

    // ============================================================
    // reload value
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reload_reg <= '0;
        end else if (load_i) begin
            reload_reg <= load_val_i;
        end
    end

    // ============================================================
    // count downward; reload of zero gives the full 2^WIDTH period
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_reg <= '0;
            out_reg <= 1'b0;
        end else if (load_i) begin
            count_reg <= load_val_i;
            out_reg <= 1'b0;
        end else if (tick_i) begin
            if (count_reg == WIDTH'(1)) begin
                count_reg <= reload_reg;
                out_reg <= 1'b1;
            end else begin
                count_reg <= count_reg - WIDTH'(1);
                out_reg <= 1'b0;
            end
        end else begin
            out_reg <= 1'b0;
        end
    end

    assign count_o = count_reg;
    assign out_pulse_o = out_reg;

endmodule : down_counter
`default_nettype wire

// [isa_dma_host.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// host dma controller: acknowledges the requesting channel
module isa_dma_host (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic slow_i,
    input wire logic drq1_i,
    input wire logic drq3_i,
    output logic dack1_n_o,
    output logic dack3_n_o
);
    logic [3:0] wait_reg;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_reg <= 4'h0;
            dack1_n_o <= 1'b1;
            dack3_n_o <= 1'b1;
        end else if (drq1_i || drq3_i) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == (slow_i ? 4'hc : 4'h1)) begin
                dack1_n_o <= !drq1_i;
                dack3_n_o <= !drq3_i;
            end
        end else begin
            wait_reg <= 4'h0;
            dack1_n_o <= 1'b1;
            dack3_n_o <= 1'b1;
        end
    end
endmodule : isa_dma_host
`default_nettype wire

// [test_isa_card_decode_and_config_select.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench
module test_isa_card_decode_and_config_select;
    logic core_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [9:0] addr_i = 10'h000;
    logic aen_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, slow = 1'b0;
    logic [15:0] wdata_i = 16'h0000;
    logic [4:0] base_select_switch_i = 5'h02;
    logic trigger_source_jumper_i = 1'b0, clock_source_jumper_i = 1'b0;
    logic dma_channel_jumper_a_i = 1'b1, dma_channel_jumper_b_i = 1'b0;
    logic [3:0] irq_select_i = 4'hf;
    logic ext_trigger_i = 1'b0, ext_clock_i = 1'b0, data_ready_i = 1'b0;
    wire logic dack1_n_i, dack3_n_i, card_select_o, drq1_o, drq3_o;
    wire logic dma_ack_o, adc_start_o, irq_o;
    wire logic [15:0] rdata_o, irq_line_o, irq_line_oe_o;
    wire logic [2:0] counter_out_o;
    wire logic [6:0] probe;
    int error_cnt = 0, cmp_count = 0, c;
    logic [15:0] d;
    logic s;
    assign probe = {irq_o, drq3_o, drq1_o, adc_start_o, counter_out_o};

    acq_decode #(.OSC_DIV(4)) DUT (
        .core_clk_i, .arst_n_i, .addr_i, .aen_i, .wr_i, .rd_i, .wdata_i,
        .rdata_o, .card_select_o, .base_select_switch_i,
        .trigger_source_jumper_i, .clock_source_jumper_i,
        .dma_channel_jumper_a_i, .dma_channel_jumper_b_i, .irq_select_i,
        .ext_trigger_i, .ext_clock_i, .data_ready_i, .dack1_n_i, .dack3_n_i,
        .drq1_o, .drq3_o, .dma_ack_o, .adc_start_o, .counter_out_o,
        .irq_line_o, .irq_line_oe_o, .irq_o
    );
    isa_dma_host host (
        .core_clk_i, .arst_n_i, .slow_i(slow), .drq1_i(drq1_o),
        .drq3_i(drq3_o), .dack1_n_o(dack1_n_i), .dack3_n_o(dack3_n_i)
    );

    always #2.5 core_clk_i = ~core_clk_i;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [9:0] ra(input logic [3:0] i);
        return {1'b1, 5'h02, i};
    endfunction : ra

    task automatic bus_wr(input logic [9:0] a, input logic [15:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [9:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
        s = card_select_o;
    endtask : bus_rd

    task automatic wait_bit(input int i, input logic v, input int n,
                            output int k);
        #1;
        k = 0;
        while (probe[i] !== v && k < n) begin
            @(posedge core_clk_i);
            #1;
            k++;
        end
    endtask : wait_bit

    task automatic gap(input int i, output int k);
        wait_bit(i, 1'b1, 40, k);
        wait_bit(i, 1'b0, 4, k);
        wait_bit(i, 1'b1, 40, k);
    endtask : gap

    task automatic settle;
        repeat (4) @(posedge core_clk_i);
    endtask : settle

    task automatic t_decode;
        logic [4:0] tab [4] = '{5'h00, 5'h10, 5'h01, 5'h1f};
        logic [9:0] a;
        #1;
        chk(irq_line_oe_o, 16'h8000);
        bus_wr(ra(4'h8), 16'h0005);
        bus_rd(ra(4'h8));
        chk({s, d}, {1'b1, 16'h0005});
        bus_rd(ra(4'hf));
        chk({s, d}, {1'b1, 16'h0000});
        bus_rd(10'h238);
        chk(s, 1'b0);
        bus_rd(10'h028);
        chk(s, 1'b0);
        aen_i <= 1'b1;
        bus_rd(ra(4'h8));
        aen_i <= 1'b0;
        chk({s, d}, 17'h0_0000);
        foreach (tab[i]) begin
            base_select_switch_i <= tab[i];
            a = {1'b1, tab[i], 4'h8};
            settle;
            bus_wr(a, 16'h0003);
            bus_rd(a);
            chk({s, d}, {1'b1, 16'h0003});
            bus_rd(a ^ 10'h100);
            chk(s, 1'b0);
        end
        base_select_switch_i <= 5'h02;
        settle;
    endtask : t_decode

    task automatic t_irq;
        bus_wr(ra(4'h7), 16'h0007);
        bus_wr(ra(4'h4), 16'h0000);
        bus_wr(ra(4'h8), 16'h0001);
        bus_wr(ra(4'h5), 16'h0000);
        wait_bit(3, 1'b1, 4, c);
        chk(c < 4, 1'b1);
        wait_bit(6, 1'b1, 6, c);
        chk(irq_line_o, 16'h8000);
        bus_rd(ra(4'h6));
        chk(d, 16'h0001);
        bus_wr(ra(4'h7), 16'h0001);
        wait_bit(6, 1'b0, 6, c);
        chk(irq_line_o, 16'h0000);
        bus_wr(ra(4'h8), 16'h0000);
        bus_wr(ra(4'h5), 16'h0000);
        irq_select_i <= 4'h5;
        settle;
        #1;
        chk({irq_o, irq_line_oe_o}, 17'h0_0020);
        irq_select_i <= 4'hf;
        bus_wr(ra(4'h7), 16'h0007);
    endtask : t_irq

    task automatic t_trig;
        trigger_source_jumper_i <= 1'b1;
        settle;
        bus_wr(ra(4'h5), 16'h0000);
        wait_bit(3, 1'b1, 8, c);
        chk(c, 8);
        ext_trigger_i <= 1'b1;
        wait_bit(3, 1'b1, 12, c);
        chk(c < 12, 1'b1);
        ext_trigger_i <= 1'b0;
        trigger_source_jumper_i <= 1'b0;
        settle;
    endtask : t_trig

    task automatic t_pacer;
        bus_wr(ra(4'h2), 16'h0002);
        bus_wr(ra(4'h1), 16'h0003);
        bus_wr(ra(4'h4), 16'h0001);
        gap(2, c);
        chk(c, 7);
        gap(1, c);
        chk(c, 23);
        gap(3, c);
        chk(c, 23);
        bus_wr(ra(4'h4), 16'h0000);
    endtask : t_pacer

    task automatic t_count;
        clock_source_jumper_i <= 1'b1;
        settle;
        bus_wr(ra(4'h0), 16'h0010);
        bus_rd(ra(4'h0));
        chk(d, 16'h0010);
        repeat (5) begin
            ext_clock_i <= 1'b1;
            settle;
            ext_clock_i <= 1'b0;
            settle;
        end
        bus_rd(ra(4'h0));
        chk(d, 16'h000b);
        clock_source_jumper_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        bus_rd(ra(4'h0));
        chk(d < 16'h000b, 1'b1);
        wait_bit(0, 1'b1, 80, c);
        chk(c < 80, 1'b1);
    endtask : t_count

    task automatic t_dma(input int i, input logic [1:0] exp);
        @(posedge core_clk_i);
        data_ready_i <= 1'b1;
        @(posedge core_clk_i);
        data_ready_i <= 1'b0;
        wait_bit(i, 1'b1, 6, c);
        chk({drq1_o, drq3_o}, exp);
        wait_bit(i, 1'b0, 30, c);
        chk(c > (slow ? 10 : 0) && c < 30, 1'b1);
        chk(dma_ack_o, 1'b1);
    endtask : t_dma

    task automatic t_dma_off;
        dma_channel_jumper_b_i <= 1'b0;
        settle;
        @(posedge core_clk_i);
        data_ready_i <= 1'b1;
        @(posedge core_clk_i);
        data_ready_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk({drq1_o, drq3_o}, 2'b00);
    endtask : t_dma_off

    task automatic close_out;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (2) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        t_decode;
        t_irq;
        t_trig;
        t_pacer;
        t_count;
        t_dma(4, 2'b10);
        dma_channel_jumper_a_i <= 1'b0;
        dma_channel_jumper_b_i <= 1'b1;
        slow <= 1'b1;
        settle;
        t_dma(5, 2'b01);
        t_dma_off;
        close_out;
    end

    initial begin
        #100000;
        error_cnt++;
        close_out;
    end
endmodule : test_isa_card_decode_and_config_select
`default_nettype wire
